// File: src/ssa_pkg.sv
// Shared constants and carriers of the SIMD shift and accumulate unit.
// Assumes a single core clock domain shared by the pipeline and the bus.
package ssa_pkg;

    // Register offsets on the AHB-Lite slave.
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_IRQ_EN  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h0C;

    // Control field positions and reset values.
    localparam int          CTRL_ENABLE_BIT    = 0;
    localparam int          CTRL_OUFLAG_BIT    = 22;
    localparam logic        CTRL_ENABLE_RESET  = 1'b1;
    localparam logic        CTRL_OUFLAG_RESET  = 1'b0;
    localparam int          EVENT_COUNT        = 3;
    localparam int          EV_OVERFLOW        = 0;
    localparam int          EV_RESERVED        = 1;
    localparam int          EV_DISABLED        = 2;
    localparam logic [2:0]  EVENT_RESET        = 3'h0;

    // Instruction field encodings.
    localparam logic [5:0]  MAJOR_OPCODE       = 6'h1F;
    localparam logic [5:0]  FUNC_ACC_GROUP     = 6'h38;
    localparam logic [5:0]  FUNC_OCT_BYTE      = 6'h17;
    localparam logic [5:0]  FUNC_QUAD_GROUP    = 6'h13;
    localparam logic [4:0]  SUB_ACC_IMM        = 5'h1A;
    localparam logic [4:0]  SUB_ACC_VAR        = 5'h1B;
    localparam logic [4:0]  SUB_BYTE           = 5'h00;
    localparam logic [4:0]  SUB_PAIR_HW        = 5'h08;
    localparam logic [4:0]  SUB_PAIR_HW_SAT    = 5'h0C;

    // Saturation limits of a halfword.
    localparam logic [15:0] HALF_MAX_POS       = 16'h7FFF;
    localparam logic [15:0] HALF_MAX_NEG       = 16'h8000;

    typedef enum {
        OP_NONE,
        OP_ACC_IMM,
        OP_ACC_VAR,
        OP_OCT_BYTE,
        OP_QUAD_BYTE,
        OP_PAIR_HW,
        OP_PAIR_HW_SAT
    } ssa_op_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] instr;
        logic [63:0] rt_value;
        logic [63:0] rs_value;
        logic [63:0] acc_hi;
        logic [63:0] acc_lo;
    } ssa_req_t;

    typedef struct packed {
        logic        valid;
        logic        gpr_write;
        logic        acc_write;
        logic [1:0]  acc_sel;
        logic [4:0]  dest;
        logic [63:0] gpr_result;
        logic [63:0] hi_result;
        logic [63:0] lo_result;
        logic        exc_reserved;
        logic        exc_disabled;
    } ssa_rsp_t;

endpackage

// File: src/ssa_unit.sv
// SIMD shift and accumulate execution unit with its AHB-Lite control slave.
// Assumes the pipeline issues at most one instruction a cycle on the core clock
// and supplies the selected accumulator pair with the request.
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps

module ssa_unit #(
    parameter int ADDR_BITS = 8
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    input  wire ssa_pkg::ssa_req_t req,
    output ssa_pkg::ssa_rsp_t     rsp,
    output logic                  irq
);

    // Refuses address widths that cannot hold the register map or the bus address.
    if (ADDR_BITS < 4 || ADDR_BITS > 32) begin : g_bad_addr_bits
        $error("ADDR_BITS must lie between 4 and 32.");
    end

    function automatic ssa_pkg::ssa_op_t decode_op(input logic [31:0] instr);
        ssa_pkg::ssa_op_t op;
        op = ssa_pkg::OP_NONE;
        if (instr[31:26] == ssa_pkg::MAJOR_OPCODE) begin
            case (instr[5:0])
                ssa_pkg::FUNC_ACC_GROUP: begin
                    if (instr[10:6] == ssa_pkg::SUB_ACC_IMM) op = ssa_pkg::OP_ACC_IMM;
                    if (instr[10:6] == ssa_pkg::SUB_ACC_VAR) op = ssa_pkg::OP_ACC_VAR;
                end
                ssa_pkg::FUNC_OCT_BYTE: begin
                    if (instr[10:6] == ssa_pkg::SUB_BYTE) op = ssa_pkg::OP_OCT_BYTE;
                end
                ssa_pkg::FUNC_QUAD_GROUP: begin
                    if (instr[10:6] == ssa_pkg::SUB_BYTE) op = ssa_pkg::OP_QUAD_BYTE;
                    if (instr[10:6] == ssa_pkg::SUB_PAIR_HW) op = ssa_pkg::OP_PAIR_HW;
                    if (instr[10:6] == ssa_pkg::SUB_PAIR_HW_SAT) op = ssa_pkg::OP_PAIR_HW_SAT;
                end
                default: begin
                    op = ssa_pkg::OP_NONE;
                end
            endcase
        end
        return op;
    endfunction

    function automatic logic [8:0] shift_byte(input logic [7:0] a, input logic [2:0] s,
                                             input logic quad);
        logic [7:0] x;
        logic       ov;
        x  = a ^ {8{a[7]}};
        ov = 1'b0;
        if (s != 3'h0) begin
            if (quad) begin
                ov = a[7] | ((a[6:0] >> (3'h7 - s)) != 7'h00);
            end else begin
                ov = (x >> (4'h8 - {1'b0, s})) != 8'h00;
            end
        end
        return {ov, 8'(a << s)};
    endfunction

    function automatic logic [16:0] shift_half(input logic [15:0] a, input logic [3:0] s,
                                              input logic sat);
        logic [14:0] x;
        logic        ov;
        logic [15:0] v;
        x  = a[14:0] ^ {15{a[15]}};
        ov = 1'b0;
        v  = a;
        if (s != 4'h0) begin
            ov = (x >> (4'hF - s)) != 15'h0000;
            v  = 16'(a << s);
            if (ov && sat) begin
                v = a[15] ? ssa_pkg::HALF_MAX_NEG : ssa_pkg::HALF_MAX_POS;
            end
        end
        return {ov, v};
    endfunction

    logic [ADDR_BITS-1:0] wr_addr_reg;
    logic                 wr_pend_reg;
    logic                 ctrl_enable_reg;
    logic                 ouflag_reg;
    logic [2:0]           status_reg;
    logic [2:0]           irq_en_reg;
    logic [2:0]           status_next;
    logic [2:0]           events;
    logic                 addr_phase;
    logic [31:0]          read_value;
    ssa_pkg::ssa_op_t     op;
    ssa_pkg::ssa_rsp_t    rsp_next;
    logic                 overflow_hit;
    logic [63:0]          oct_val;
    logic [7:0]           oct_ov;
    logic [31:0]          quad_val;
    logic [3:0]           quad_ov;
    logic [31:0]          half_val;
    logic [1:0]           half_ov;

    assign op = decode_op(req.instr);

    generate
        for (genvar i = 0; i < 8; i++) begin : g_byte
            logic [8:0] oct_r;
            assign oct_r              = shift_byte(req.rt_value[8*i +: 8], req.instr[23:21], 1'b0);
            assign oct_val[8*i +: 8]  = oct_r[7:0];
            assign oct_ov[i]          = oct_r[8];
            if (i < 4) begin : g_quad
                logic [8:0] quad_r;
                assign quad_r              = shift_byte(req.rt_value[8*i +: 8],
                                                        req.instr[23:21], 1'b1);
                assign quad_val[8*i +: 8]  = quad_r[7:0];
                assign quad_ov[i]          = quad_r[8];
            end
        end
        for (genvar j = 0; j < 2; j++) begin : g_half
            logic [16:0] half_r;
            assign half_r               = shift_half(req.rt_value[16*j +: 16], req.instr[24:21],
                                                     op == ssa_pkg::OP_PAIR_HW_SAT);
            assign half_val[16*j +: 16] = half_r[15:0];
            assign half_ov[j]           = half_r[16];
        end
    endgenerate

    always_comb begin
        logic [5:0]  amount;
        logic [5:0]  mag;
        logic [63:0] acc;
        logic [63:0] t;
        amount   = 6'h00;
        mag      = 6'h00;
        acc      = {req.acc_hi[31:0], req.acc_lo[31:0]};
        t        = acc;
        rsp_next = '0;
        overflow_hit = 1'b0;
        rsp_next.valid   = req.valid;
        rsp_next.dest    = req.instr[15:11];
        rsp_next.acc_sel = req.instr[12:11];
        if (req.valid) begin
            if (op == ssa_pkg::OP_NONE) begin
                rsp_next.exc_reserved = 1'b1;
            end else if (!ctrl_enable_reg) begin
                rsp_next.exc_disabled = 1'b1;
            end else begin
                case (op)
                    ssa_pkg::OP_ACC_IMM, ssa_pkg::OP_ACC_VAR: begin
                        amount = (op == ssa_pkg::OP_ACC_VAR) ? req.rs_value[5:0]
                                                             : req.instr[25:20];
                        mag    = amount[5] ? 6'(-amount) : amount;
                        t      = amount[5] ? (acc << mag) : (acc >> mag);
                        rsp_next.acc_write = 1'b1;
                        rsp_next.hi_result = {{32{t[63]}}, t[63:32]};
                        rsp_next.lo_result = {{32{t[63]}}, t[31:0]};
                    end
                    ssa_pkg::OP_OCT_BYTE: begin
                        rsp_next.gpr_write  = 1'b1;
                        rsp_next.gpr_result = oct_val;
                        overflow_hit        = |oct_ov;
                    end
                    ssa_pkg::OP_QUAD_BYTE: begin
                        rsp_next.gpr_write  = 1'b1;
                        rsp_next.gpr_result = {{32{quad_val[31]}}, quad_val};
                        overflow_hit        = |quad_ov;
                    end
                    ssa_pkg::OP_PAIR_HW, ssa_pkg::OP_PAIR_HW_SAT: begin
                        rsp_next.gpr_write  = 1'b1;
                        rsp_next.gpr_result = {{32{half_val[31]}}, half_val};
                        overflow_hit        = |half_ov;
                    end
                    default: begin
                        rsp_next.exc_reserved = 1'b1;
                    end
                endcase
            end
        end
    end

    assign events = {rsp_next.exc_disabled, rsp_next.exc_reserved, overflow_hit};

    assign addr_phase = hsel && htrans[1] && hready;

    always_comb begin
        read_value = 32'h0000_0000;
        case (haddr[ADDR_BITS-1:0])
            ADDR_BITS'(ssa_pkg::ADDR_CTRL): begin
                read_value[ssa_pkg::CTRL_ENABLE_BIT] = ctrl_enable_reg;
                read_value[ssa_pkg::CTRL_OUFLAG_BIT] = ouflag_reg;
            end
            ADDR_BITS'(ssa_pkg::ADDR_STATUS): begin
                read_value[2:0] = status_reg;
            end
            ADDR_BITS'(ssa_pkg::ADDR_IRQ_EN): begin
                read_value[2:0] = irq_en_reg;
            end
            default: begin
                read_value = 32'h0000_0000;
            end
        endcase
    end

    // Bus slave: zero wait states, always OKAY, read data latched in the address phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
            hrdata      <= 32'h0000_0000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            wr_pend_reg <= addr_phase && hwrite;
            wr_addr_reg <= haddr[ADDR_BITS-1:0];
            hrdata      <= (addr_phase && !hwrite) ? read_value : 32'h0000_0000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end
    end

    // Control register: hardware setting of the overflow flag wins over a write.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_enable_reg <= ssa_pkg::CTRL_ENABLE_RESET;
            ouflag_reg      <= ssa_pkg::CTRL_OUFLAG_RESET;
        end else begin
            if (wr_pend_reg && wr_addr_reg == ADDR_BITS'(ssa_pkg::ADDR_CTRL)) begin
                ctrl_enable_reg <= hwdata[ssa_pkg::CTRL_ENABLE_BIT];
                ouflag_reg      <= hwdata[ssa_pkg::CTRL_OUFLAG_BIT] | overflow_hit;
            end else if (overflow_hit) begin
                ouflag_reg <= 1'b1;
            end
        end
    end

    always_comb begin
        status_next = status_reg;
        if (wr_pend_reg && wr_addr_reg == ADDR_BITS'(ssa_pkg::ADDR_IRQ_CLR)) begin
            status_next = status_reg & ~hwdata[2:0];
        end
        status_next = status_next | events;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_reg <= ssa_pkg::EVENT_RESET;
            irq_en_reg <= ssa_pkg::EVENT_RESET;
            irq        <= 1'b0;
        end else begin
            status_reg <= status_next;
            if (wr_pend_reg && wr_addr_reg == ADDR_BITS'(ssa_pkg::ADDR_IRQ_EN)) begin
                irq_en_reg <= hwdata[2:0];
            end
            irq <= |(status_next & irq_en_reg);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rsp <= '0;
        end else begin
            rsp <= rsp_next;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence acc_issue_s;
        req.valid && ctrl_enable_reg &&
            (op == ssa_pkg::OP_ACC_IMM || op == ssa_pkg::OP_ACC_VAR);
    endsequence

    sequence half_issue_s;
        req.valid && ctrl_enable_reg &&
            (op == ssa_pkg::OP_PAIR_HW || op == ssa_pkg::OP_PAIR_HW_SAT);
    endsequence

    acc_select_a: assert property (acc_issue_s |=> rsp.acc_write &&
            rsp.acc_sel == $past(req.instr[12:11]))
        else $error("Accumulator select not carried to result.");

    right_fill_a: assert property (acc_issue_s ##0 (op == ssa_pkg::OP_ACC_IMM &&
            !req.instr[25] && req.instr[25:20] != 6'h00) |=> rsp.hi_result[31] == 1'b0)
        else $error("Right shift did not fill with zeros.");

    zero_shift_a: assert property (acc_issue_s ##0 (op == ssa_pkg::OP_ACC_VAR &&
            req.rs_value[5:0] == 6'h00) |=> rsp.lo_result[31:0] == $past(req.acc_lo[31:0]) &&
            rsp.hi_result[31:0] == $past(req.acc_hi[31:0]))
        else $error("Zero accumulator shift changed the value.");

    left_full_a: assert property (acc_issue_s ##0 (op == ssa_pkg::OP_ACC_VAR &&
            req.rs_value[5:0] == 6'h20) |=> rsp.lo_result[31:0] == 32'h0000_0000 &&
            rsp.hi_result[31:0] == $past(req.acc_lo[31:0]))
        else $error("Shift by minus 32 gave a wrong result.");

    acc_extend_a: assert property (rsp.acc_write |->
            rsp.hi_result[63:32] == {32{rsp.hi_result[31]}} &&
            rsp.lo_result[63:32] == {32{rsp.hi_result[31]}})
        else $error("Accumulator halves not sign-extended from bit 63.");

    oct_flag_a: assert property (req.valid && ctrl_enable_reg &&
            op == ssa_pkg::OP_OCT_BYTE && req.instr[23:21] == 3'h2 &&
            req.rt_value[7:6] == 2'b01 |=> ouflag_reg && status_reg[ssa_pkg::EV_OVERFLOW])
        else $error("Octal byte overflow did not set the flag.");

    quad_extend_a: assert property (req.valid && ctrl_enable_reg &&
            op == ssa_pkg::OP_QUAD_BYTE |=> rsp.gpr_write &&
            rsp.gpr_result[63:32] == {32{rsp.gpr_result[31]}})
        else $error("Quad byte result not sign-extended.");

    sat_value_a: assert property (half_issue_s ##0 (op == ssa_pkg::OP_PAIR_HW_SAT &&
            req.instr[24:21] != 4'h0 && req.rt_value[15:14] == 2'b01)
            |=> rsp.gpr_result[15:0] == ssa_pkg::HALF_MAX_POS)
        else $error("Positive halfword did not saturate to the top value.");

    half_pass_a: assert property (half_issue_s ##0 (req.instr[24:21] == 4'h0 &&
            !ouflag_reg) |=> rsp.gpr_result[31:0] == $past(req.rt_value[31:0]) && !ouflag_reg)
        else $error("Zero halfword shift altered data or flagged overflow.");

    no_data_exc_a: assert property (req.valid && ctrl_enable_reg &&
            op != ssa_pkg::OP_NONE |=> !rsp.exc_reserved && !rsp.exc_disabled)
        else $error("Data-dependent exception raised.");

    disabled_exc_a: assert property (req.valid && !ctrl_enable_reg &&
            op != ssa_pkg::OP_NONE |=> rsp.exc_disabled && !rsp.gpr_write && !rsp.acc_write
            ##1 status_reg[ssa_pkg::EV_DISABLED])
        else $error("Disabled extension still executed.");

endmodule // ssa_unit

// File: sim/ssa_pipe_model.sv
// Pipeline model for the SIMD shift unit: holds four accumulator pairs and issues requests.
// Assumes the bench drives issue, instruction and operands right after a rising edge.
`timescale 1ns/100ps

module ssa_pipe_model (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              issue,
    input  wire logic [31:0]       instr,
    input  wire logic [63:0]       rt_value,
    input  wire logic [63:0]       rs_value,
    input  wire logic              seed_en,
    input  wire logic [63:0]       seed_value,
    output ssa_pkg::ssa_req_t      req,
    input  wire ssa_pkg::ssa_rsp_t rsp
);
    logic [63:0] acc_reg [4];
    logic [63:0] sel;

    // Operands go out whole in element format; unused upper low-word bits are scrambled.
    always_comb begin
        sel          = acc_reg[instr[12:11]];
        req.valid    = issue;
        req.instr    = instr;
        req.rt_value = rt_value;
        req.rs_value = rs_value;
        req.acc_hi   = {{32{sel[63]}}, sel[63:32]};
        req.acc_lo   = {~{32{sel[31]}}, sel[31:0]};
    end

    // Results land in the pair that the response names.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 4; i++) acc_reg[i] <= 64'h0;
        end else if (seed_en) begin
            acc_reg[instr[12:11]] <= seed_value;
        end else if (rsp.valid && rsp.acc_write) begin
            acc_reg[rsp.acc_sel] <= {rsp.hi_result[31:0], rsp.lo_result[31:0]};
        end
    end
endmodule  // ssa_pipe_model

// File: sim/simd_shift_accumulator_unit_tb.sv
// Self-checking bench of the SIMD shift unit: corner and random instructions, bus registers.
// Assumes the pipeline model beside it and a single 20 MHz clock.
`timescale 1ns/100ps

module simd_shift_accumulator_unit_tb;
    logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0]       haddr, hwdata, hrdata, instr;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    logic              issue, seed_en, ovf_exp, ext_on;
    logic [63:0]       rt_value, rs_value, seed_value;
    logic [63:0]       acc_mirror [4];
    ssa_pkg::ssa_req_t req;
    ssa_pkg::ssa_rsp_t rsp;
    int                err_count, samples_checked;
    int                c_op  [10] = '{0, 0, 0, 1, 1, 2, 3, 3, 4, 5};
    logic [5:0]        c_amt [10] = '{6'h1F, 6'h20, 6'h00, 6'h21, 6'h01, 6'h07, 6'h01, 6'h01,
                                      6'h00, 6'h01};
    logic [63:0]       c_rt  [10] = '{64'h0, 64'h0, 64'h0, 64'h0, 64'h0, 64'h7F800140FF018000,
                                      64'h1234567800000040, 64'h00000000000000C0,
                                      64'h0000000080017FFF, 64'h00000000A0004000};

    ssa_unit #(.ADDR_BITS(8)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .req(req), .rsp(rsp), .irq(irq));
    ssa_pipe_model u_pipe (.hclk(hclk), .hresetn(hresetn), .issue(issue), .instr(instr),
        .rt_value(rt_value), .rs_value(rs_value), .seed_en(seed_en), .seed_value(seed_value),
        .req(req), .rsp(rsp));

    task automatic tally_and_finish;
        $display("Checks made: %0d, mismatches: %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(logic [63:0] got, logic [63:0] exp, string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic bus(logic wr, logic [7:0] a, logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask

    task automatic rd_chk(logic [7:0] a, logic [31:0] exp, string what);
        logic [31:0] r;
        bus(1'h0, a, 32'h0, r);
        chk(64'(r), 64'(exp), what);
        chk(64'(hresp), 64'h0, "response");
    endtask

    function automatic logic [16:0] elem_shl(logic [15:0] a, int w, int s, bit skip, bit zonly,
                                             bit sat);
        logic [15:0] mask, src, disc, res;
        logic        ovf;
        mask = 16'hFFFF >> (16 - w);
        res  = (a << s) & mask;
        src  = skip ? ((a << 1) & mask) : a;
        disc = ((16'hFFFF << s) & {16{a[w-1]}} | (src >> (w - s))) & mask;
        ovf  = (s != 0) && (disc != 16'h0) && (zonly || disc != mask);
        if (ovf && sat) res = a[w-1] ? 16'h8000 : 16'h7FFF;
        return {ovf, res};
    endfunction

    function automatic logic [64:0] vec_exp(int op, logic [63:0] rt, int s);
        logic [16:0] e;
        logic [63:0] r;
        logic        ovf;
        int          w, n;
        w   = (op >= 4) ? 16 : 8;
        n   = (op == 2) ? 8 : ((op == 3) ? 4 : 2);
        r   = 64'h0;
        ovf = 1'h0;
        for (int i = 0; i < n; i++) begin
            e   = elem_shl(16'(rt >> (w * i)) & (16'hFFFF >> (16 - w)), w, s, op != 2, op == 3,
                           op == 5);
            r   = r | (64'(e[15:0]) << (w * i));
            ovf = ovf | e[16];
        end
        if (op != 2) r[63:32] = {32{r[31]}};
        return {ovf, r};
    endfunction

    function automatic logic [63:0] acc_exp(logic [63:0] a, logic [5:0] s);
        logic [5:0] mag;
        mag = -s;
        return s[5] ? (a << mag) : (a >> s);
    endfunction

    task automatic exec(int op, logic [63:0] rt, logic [63:0] rs, logic [5:0] amt, logic [1:0] ac);
        logic [31:0] ins, r;
        logic [64:0] v;
        logic [63:0] t;
        logic [4:0]  rd, ef, gf;
        logic [3:0]  s;
        logic        res, go;
        rd  = rs[10:6];
        s   = (op >= 4) ? amt[3:0] : {1'h0, amt[2:0]};
        res = (op == 6);
        go  = !res && ext_on;
        rs  = (op == 1) ? {rs[63:6], amt} : rs;
        case (op)
            0: ins = {6'h1F, amt, 4'h0, 3'h0, ac, 5'h1A, 6'h38};
            1: ins = {6'h1F, rd, 5'h00, 3'h0, ac, 5'h1B, 6'h38};
            2: ins = {6'h1F, 2'h0, s[2:0], rd, rd, 5'h00, 6'h17};
            3: ins = {6'h1F, 2'h0, s[2:0], rd, rd, 5'h00, 6'h13};
            4: ins = {6'h1F, 1'h0, s, rd, rd, 5'h08, 6'h13};
            5: ins = {6'h1F, 1'h0, s, rd, rd, 5'h0C, 6'h13};
            default: ins = {6'h1F, 20'h0, 6'h3F};
        endcase
        t  = acc_exp(acc_mirror[ac], amt);
        v  = vec_exp(op, rt, int'(s));
        ef = {1'h1, go && op > 1, go && op < 2, res, !res && !ext_on};
        @(posedge hclk);
        issue    <= 1'h1;
        instr    <= ins;
        rt_value <= rt;
        rs_value <= rs;
        @(posedge hclk);
        issue <= 1'h0;
        @(posedge hclk);
        gf = {rsp.valid, rsp.gpr_write, rsp.acc_write, rsp.exc_reserved, rsp.exc_disabled};
        chk(64'(gf), 64'(ef), "flags");
        if (go && op < 2) begin
            chk(64'(rsp.acc_sel), 64'(ac), "acc select");
            chk(rsp.hi_result, {{32{t[63]}}, t[63:32]}, "high");
            chk(rsp.lo_result, {{32{t[63]}}, t[31:0]}, "low");
            acc_mirror[ac] = t;
        end
        if (go && op > 1) begin
            chk(64'(rsp.dest), 64'(rd), "dest");
            chk(rsp.gpr_result, v[63:0], "vector");
            ovf_exp = ovf_exp | v[64];
        end
        bus(1'h0, 8'h00, 32'h0, r);
        chk(64'(r), 64'({9'h0, ovf_exp, 21'h0, ext_on}), "control");
    endtask

    initial begin
        hclk = 1'h0;
        forever #25 hclk = ~hclk;
    end

    initial begin
        repeat (40000) @(posedge hclk);
        err_count++;
        tally_and_finish;
    end

    initial begin
        logic [31:0] r;
        int          op;
        {hresetn, hsel, hwrite, issue, seed_en, ovf_exp, ext_on} = 7'h01;
        {haddr, hwdata, instr, htrans, hsize} = {96'h0, 2'h0, 3'h2};
        {rt_value, rs_value, seed_value} = 192'h0;
        {err_count, samples_checked} = 64'h0;
        r = $urandom(32'h3F14BC30);
        repeat (5) @(posedge hclk);
        hresetn <= 1'h1;
        rd_chk(8'h00, 32'h00000001, "control reset");
        rd_chk(8'h04, 32'h00000000, "status reset");
        rd_chk(8'h08, 32'h00000000, "enable reset");
        rd_chk(8'h0C, 32'h00000000, "clear reads zero");
        rd_chk(8'h10, 32'h00000000, "unmapped");
        for (int i = 0; i < 4; i++) begin
            acc_mirror[i] = {$urandom, $urandom};
            @(posedge hclk);
            seed_en    <= 1'h1;
            instr      <= {19'h0, 2'(i), 11'h0};
            seed_value <= acc_mirror[i];
        end
        @(posedge hclk);
        seed_en <= 1'h0;
        for (int i = 0; i < 240; i++) begin
            op = (i < 10) ? c_op[i] : int'($urandom % 6);
            if (i < 10 || $urandom % 4 == 0) begin
                bus(1'h1, 8'h00, 32'h00000001, r);
                ovf_exp = 1'h0;
            end
            exec(op, (i < 10) ? c_rt[i] : {$urandom, $urandom}, {$urandom, $urandom},
                 (i < 10) ? c_amt[i] : 6'($urandom), 2'($urandom));
        end
        exec(6, 64'h0, 64'h0, 6'h00, 2'h0);
        bus(1'h1, 8'h00, 32'h00000000, r);
        {ext_on, ovf_exp} = 2'h0;
        exec(2, 64'h7F7F7F7F7F7F7F7F, 64'h0, 6'h03, 2'h0);
        exec(6, 64'h0, 64'h0, 6'h00, 2'h0);
        bus(1'h1, 8'h00, 32'h00000001, r);
        ext_on = 1'h1;
        bus(1'h1, 8'h04, 32'h00000000, r);
        rd_chk(8'h04, 32'h00000007, "status events");
        chk(64'(irq), 64'h0, "irq masked");
        bus(1'h1, 8'h08, 32'h00000002, r);
        repeat (2) @(posedge hclk);
        chk(64'(irq), 64'h1, "irq raised");
        bus(1'h1, 8'h0C, 32'h00000002, r);
        repeat (2) @(posedge hclk);
        chk(64'(irq), 64'h0, "irq cleared");
        rd_chk(8'h04, 32'h00000005, "status after clear");
        bus(1'h1, 8'h0C, 32'h00000007, r);
        rd_chk(8'h04, 32'h00000000, "status empty");
        tally_and_finish;
    end
endmodule  // simd_shift_accumulator_unit_tb
